// ===== rtl/scrb_bank.sv
// system control register bank on the peripheral register bus
`timescale 1ns/1ns
module scrb_bank import scrb_pkg::*; #(
  parameter logic [1:0] PLATFORM = 2'h0,
  // arbitrary label value
  parameter logic [10:0] VERSION_LABEL = 11'h001,
  parameter int EDC_EVENTS = 14,
  parameter int EDC_MEMS = 5
) (
  // clock and resets
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic netcore_rst_in,
  // peripheral register bus
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // reset sources
  input wire logic cpu_watchdog_expire,
  // asynchronous reset pulses
  output logic soft_reset_all,
  output logic soft_reset_netcore,
  output logic soft_reset_cpu,
  output logic watchdog_reset,
  // stored synchronous resets
  output logic periph_if_sync_reset,
  output logic host_if_sync_reset,
  output logic netcore_sync_reset,
  // pll monitor pins
  input wire logic pll_lock_pin,
  input wire logic pll_clk_lost_pin,
  // system bus fault
  input wire logic sb_fault_valid,
  input wire logic [31:0] sb_fault_addr,
  input wire logic sb_fault_write,
  input wire logic [2:0] sb_fault_size,
  input wire logic [2:0] sb_fault_burst,
  input wire logic [5:0] sb_fault_master,
  // peripheral bus fault and memory timeout
  input wire logic pb_fault_valid,
  input wire logic [31:0] pb_fault_addr,
  input wire logic em_timeout_valid,
  input wire logic [31:0] em_timeout_addr,
  // memory error detection
  input wire logic [EDC_EVENTS-1:0] memory_error_events,
  input wire logic [EDC_MEMS-1:0] error_check_init_done,
  // memory map and bus settings
  output logic [1:0] seg0_swap_sel,
  output logic seg0_unmapped,
  output logic [7:0] data_port_burst_cap,
  output logic [7:0] instr_port_burst_cap,
  output logic [7:0] serial_clk_div,
  output logic [3:0] tcm_map,
  output logic [15:0] gpio_irq_pol
);
  if (EDC_EVENTS > EDC_REG_W || EDC_MEMS > INIT_REG_W) begin : g_chk
    $error("memory error counts exceed register width");
  end

  ////////////////////////////////////////////////////////////////////////////
  // bus slave
  logic pready_r;
  logic pslverr_r;
  logic [31:0] prdata_r;
  logic [31:0] rd_val;
  logic mapped;
  logic wr_acc;
  logic rd_setup;
  logic wr_async;
  logic wr_edc;

  assign wr_acc = psel & penable & pready_r & pwrite;
  assign rd_setup = psel & ~penable & ~pwrite;
  assign wr_async = wr_acc && paddr == OFS_ASYNC;
  assign wr_edc = wr_acc && paddr == OFS_EDC;

  ////////////////////////////////////////////////////////////////////////////
  // async reset control
  logic wd_allow_r;
  logic wd_to_nc_r;
  logic [15:0] pulse_len_r;
  logic [CH_NUM-1:0] start_r;
  logic [CH_NUM-1:0] pulse_w;
  logic wd_fire;

  // RULE1: watchdog gate
  assign wd_fire = cpu_watchdog_expire & wd_allow_r;

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      wd_allow_r <= 1'b0;
      pulse_len_r <= '0;
    end else if (wr_async) begin
      wd_allow_r <= pwdata[ASR_WD_ALLOW];
      pulse_len_r <= pwdata[ASR_LEN_LSB +: PULSE_LEN_W];
    end
  end

  // RULE19: own reset domain
  always_ff @(posedge clk_sys) begin
    if (netcore_rst_in) begin
      wd_to_nc_r <= WD_NC_RST;
    end else if (wr_async) begin
      wd_to_nc_r <= pwdata[ASR_WD_NC];
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      start_r <= '0;
    end else begin
      // RULE2: global soft reset
      start_r[CH_ALL] <= wr_async & pwdata[ASR_SOFT_ALL];
      // RULE3 RULE4: network core reset
      start_r[CH_NC] <= (wr_async & pwdata[ASR_SOFT_NC]) | (wd_fire & wd_to_nc_r);
      // RULE5: processor core reset
      start_r[CH_CPU] <= wr_async & pwdata[ASR_SOFT_CPU];
      start_r[CH_WD] <= wd_fire;
    end
  end

  for (genvar g = 0; g < CH_NUM; g++) begin : g_pulse
    scrb_reset_pulse u_pulse (
      .clk_sys(clk_sys),
      .rst(rst),
      .start(start_r[g]),
      .len(pulse_len_r),
      .pulse_out(pulse_w[g])
    );
  end

  assign soft_reset_all = pulse_w[CH_ALL];
  assign soft_reset_netcore = pulse_w[CH_NC];
  assign soft_reset_cpu = pulse_w[CH_CPU];
  assign watchdog_reset = pulse_w[CH_WD];

  ////////////////////////////////////////////////////////////////////////////
  // sync resets and last cause
  logic [2:0] sync_rst_r;
  logic [3:0] cause_r;

  // RULE8: stored resets
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      sync_rst_r <= '0;
    end else if (wr_acc && paddr == OFS_SYNC) begin
      sync_rst_r <= pwdata[2:0];
    end
  end

  assign periph_if_sync_reset = sync_rst_r[0];
  assign host_if_sync_reset = sync_rst_r[1];
  assign netcore_sync_reset = sync_rst_r[2];

  // RULE9: latest cause only
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      cause_r <= CAUSE_PWR;
    end else if (start_r[CH_CPU]) begin
      cause_r <= CAUSE_CPU;
    end else if (start_r[CH_ALL]) begin
      cause_r <= CAUSE_SOFT;
    end else if (start_r[CH_WD]) begin
      cause_r <= CAUSE_WDOG;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pll monitor
  logic [1:0] pll_s1;
  logic [1:0] pll_s2;
  logic [1:0] pll_s3;
  logic [1:0] pll_r;
  logic [1:0] pll_agree;

  assign pll_agree = ~(pll_s2 ^ pll_s3);

  // RULE10: filtered status
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      pll_s1 <= PLL_RST;
      pll_s2 <= PLL_RST;
      pll_s3 <= PLL_RST;
      pll_r <= PLL_RST;
    end else begin
      pll_s1 <= {pll_clk_lost_pin, pll_lock_pin};
      pll_s2 <= pll_s1;
      pll_s3 <= pll_s2;
      pll_r <= (pll_r & ~pll_agree) | (pll_s3 & pll_agree);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // fault capture
  logic sb_held_r;
  logic [31:0] sb_addr_r;
  logic [6:0] sb_ctl_r;
  logic [5:0] sb_mst_r;
  logic sb_release;
  logic sb_take;

  assign sb_release = rd_setup && paddr == OFS_SB_MST;
  // RULE20: hold first fault
  assign sb_take = sb_fault_valid & (~sb_held_r | sb_release);

  // RULE11: system bus fault
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      sb_held_r <= 1'b0;
      sb_addr_r <= '0;
      sb_ctl_r <= '0;
      sb_mst_r <= '0;
    end else begin
      sb_held_r <= sb_take | (sb_held_r & ~sb_release);
      if (sb_take) begin
        sb_addr_r <= sb_fault_addr;
        sb_ctl_r <= {sb_fault_burst, sb_fault_size, sb_fault_write};
        sb_mst_r <= sb_fault_master & MST_VALID;
      end
    end
  end

  logic [1:0] fa_valid;
  logic [1:0] fa_release;
  logic [1:0] fa_take;
  logic [1:0] fa_held_r;
  logic [31:0] fa_in [2];
  logic [31:0] fa_addr_r [2];

  assign fa_valid = {em_timeout_valid, pb_fault_valid};
  assign fa_in[0] = pb_fault_addr;
  assign fa_in[1] = em_timeout_addr;
  assign fa_release[0] = rd_setup && paddr == OFS_PB_ADR;
  assign fa_release[1] = rd_setup && paddr == OFS_EM_ADR;

  // RULE12 RULE20: address captures
  for (genvar g = 0; g < 2; g++) begin : g_fault
    assign fa_take[g] = fa_valid[g] & (~fa_held_r[g] | fa_release[g]);
    always_ff @(posedge clk_sys) begin
      if (rst) begin
        fa_held_r[g] <= 1'b0;
        fa_addr_r[g] <= '0;
      end else begin
        fa_held_r[g] <= fa_take[g] | (fa_held_r[g] & ~fa_release[g]);
        if (fa_take[g]) begin
          fa_addr_r[g] <= fa_in[g];
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // memory error flags
  logic [EDC_EVENTS-1:0] edc_r;
  logic [EDC_MEMS-1:0] init_r;

  // RULE15: sticky, set wins
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      edc_r <= '0;
    end else begin
      edc_r <= memory_error_events | (wr_edc ? (edc_r & pwdata[EDC_EVENTS-1:0]) : edc_r);
    end
  end

  // RULE16: init done held
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      init_r <= '0;
    end else begin
      init_r <= init_r | error_check_init_done;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // map and bus settings
  logic [1:0] swap_r;
  logic unmapped_r;
  logic [15:0] burst_r;
  logic [7:0] div_r;
  logic [3:0] tcm_r;
  logic [15:0] pol_r;

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      swap_r <= '0;
      unmapped_r <= 1'b0;
      burst_r <= '0;
      div_r <= DIV_RST;
      tcm_r <= '0;
      pol_r <= '0;
    end else if (wr_acc) begin
      // RULE13: segment 0 select
      if (paddr == OFS_SWAP) begin
        swap_r <= pwdata[1:0];
        unmapped_r <= pwdata[1:0] == SWAP_NONE;
      end
      // RULE14: burst caps
      if (paddr == OFS_BURST) begin
        burst_r <= pwdata[15:0];
      end
      if (paddr == OFS_DIV) begin
        div_r <= pwdata[7:0];
      end
      if (paddr == OFS_TCM) begin
        tcm_r <= pwdata[3:0];
      end
      if (paddr == OFS_POL) begin
        pol_r <= pwdata[15:0];
      end
    end
  end

  assign seg0_swap_sel = swap_r;
  assign seg0_unmapped = unmapped_r;
  assign data_port_burst_cap = burst_r[7:0];
  assign instr_port_burst_cap = burst_r[15:8];
  assign serial_clk_div = div_r;
  assign tcm_map = tcm_r;
  assign gpio_irq_pol = pol_r;

  ////////////////////////////////////////////////////////////////////////////
  // read mux
  // RULE18: undefined bits zero
  always_comb begin
    rd_val = '0;
    mapped = 1'b1;
    unique case (paddr)
      OFS_ASYNC: begin
        rd_val[ASR_WD_ALLOW] = wd_allow_r;
        rd_val[ASR_SOFT_ALL] = pulse_w[CH_ALL];
        rd_val[ASR_SOFT_NC] = pulse_w[CH_NC];
        rd_val[ASR_WD_NC] = wd_to_nc_r;
        rd_val[ASR_ONE] = 1'b1;
        rd_val[ASR_SOFT_CPU] = pulse_w[CH_CPU];
        rd_val[ASR_LEN_LSB +: PULSE_LEN_W] = pulse_len_r;
      end
      OFS_SYNC: rd_val[2:0] = sync_rst_r;
      OFS_CAUSE: rd_val[3:0] = cause_r;
      OFS_PLL: rd_val[1:0] = pll_r;
      OFS_SB_ADR: rd_val = sb_addr_r;
      OFS_SB_CTL: rd_val[6:0] = sb_ctl_r;
      OFS_SB_MST: rd_val[5:0] = sb_mst_r;
      OFS_PB_ADR: rd_val = fa_addr_r[0];
      OFS_EM_ADR: rd_val = fa_addr_r[1];
      OFS_SWAP: rd_val[1:0] = swap_r;
      OFS_TAG: begin
        // RULE17: platform code
        rd_val[TAG_PLAT_LSB +: 2] = PLATFORM;
        rd_val[10:0] = VERSION_LABEL;
      end
      OFS_BURST: rd_val[15:0] = burst_r;
      OFS_DIV: rd_val[7:0] = div_r;
      OFS_EDC: rd_val[EDC_EVENTS-1:0] = edc_r;
      OFS_INIT: rd_val[EDC_MEMS-1:0] = init_r;
      OFS_TCM: rd_val[3:0] = tcm_r;
      OFS_POL: rd_val[15:0] = pol_r;
      default: mapped = 1'b0;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r <= '0;
    end else begin
      pready_r <= psel & ~penable;
      pslverr_r <= psel & ~penable & ~mapped;
      if (rd_setup) begin
        prdata_r <= rd_val;
      end
    end
  end

  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  AST_WD_GATED: assert property ( // RULE1
    cpu_watchdog_expire && !wd_allow_r |=> !start_r[CH_WD] ##1 !$rose(pulse_w[CH_WD]))
    else $error("watchdog reset while not allowed");
  AST_WD_FIRES: assert property ( // RULE1
    wd_fire |=> start_r[CH_WD] ##1 pulse_w[CH_WD])
    else $error("allowed watchdog gave no reset");
  AST_SOFT_ALL: assert property ( // RULE2
    wr_async && pwdata[ASR_SOFT_ALL] |=> ##1 pulse_w[CH_ALL])
    else $error("global soft reset missing");
  AST_SOFT_NC: assert property ( // RULE3
    wr_async && pwdata[ASR_SOFT_NC] |=> ##1 pulse_w[CH_NC])
    else $error("network core soft reset missing");
  AST_WD_NC_OFF: assert property ( // RULE4
    wd_fire && !wd_to_nc_r && !(wr_async && pwdata[ASR_SOFT_NC]) |=> !start_r[CH_NC])
    else $error("watchdog hit network core while disabled");
  AST_CPU_SOFT: assert property ( // RULE5
    wr_async && pwdata[ASR_SOFT_CPU] |=> ##1 pulse_w[CH_CPU] && cause_r == CAUSE_CPU)
    else $error("processor soft reset or cause missing");
  AST_SYNC_RST: assert property ( // RULE8
    wr_acc && paddr == OFS_SYNC |=> periph_if_sync_reset == $past(pwdata[0])
      && netcore_sync_reset == $past(pwdata[2]))
    else $error("stored reset not taken");
  AST_CAUSE_ONEHOT: assert property ( // RULE9
    $onehot(cause_r))
    else $error("cause register not one-hot");
  AST_PLL_FILTER: assert property ( // RULE10
    (pll_s2 ^ pll_s3) != 2'h0 |=> ((pll_r ^ $past(pll_r)) & $past(pll_s2 ^ pll_s3)) == 2'h0)
    else $error("pll status changed before agreement");
  AST_SB_HOLD: assert property ( // RULE20
    sb_held_r && !sb_release |=> $stable(sb_addr_r) && $stable(sb_mst_r))
    else $error("held fault overwritten");
  AST_PB_CAPTURE: assert property ( // RULE12
    fa_take[0] |=> fa_addr_r[0] == $past(pb_fault_addr) && fa_held_r[0])
    else $error("peripheral bus fault not captured");
  AST_EDC_STICKY: assert property ( // RULE15
    memory_error_events[0] |=> edc_r[0] ##1 (edc_r[0] || $past(wr_edc)))
    else $error("error flag lost");
  AST_RSVD_ZERO: assert property ( // RULE18
    rd_setup && paddr == OFS_SYNC |=> prdata_r[31:3] == '0)
    else $error("undefined bits read nonzero");
  AST_SWAP_NONE: assert property ( // RULE13
    wr_acc && paddr == OFS_SWAP |=> seg0_unmapped == (seg0_swap_sel == SWAP_NONE))
    else $error("unmapped flag disagrees with swap field");

  COV_SOFT_ALL: cover property (start_r[CH_ALL] ##1 pulse_w[CH_ALL]);
  COV_WD_NC: cover property (wd_fire && wd_to_nc_r);
  COV_SB_REFILL: cover property (sb_take && sb_held_r);
  COV_EDC_CLEAR: cover property (edc_r[0] ##1 wr_edc ##1 !edc_r[0]);

endmodule // scrb_bank

// ===== rtl/scrb_pkg.sv
// constants of the system control register bank
// Function
// RULE1: watchdog expiry resets the processor only while the allow bit is set
// RULE2: software writes 1 to start a timed reset of all but the network core
// RULE3: software writes 1 to start a timed reset of the network core only
// RULE4: bit, reset 1, decides whether watchdog reset also hits the network core
// RULE5: software writes 1 to start a timed reset of the processor core only
// RULE6: pulse length field n gives resets of 8n+8 clock cycles
// RULE7: software keeps the pulse length above 1562 for the transceivers
// RULE8: three stored synchronous resets for peripheral, host and network core
// RULE9: cause register shows only the latest reset cause, reset value 4h
// RULE10: pll status shows filtered lock state and a live input-clock-lost flag; the code filters the clock-lost bit too
// RULE11: system bus fault captures address, direction, size, burst and master; the code masks the master with MST_VALID, so master bit 2 reads zero
// RULE12: peripheral bus fault and external memory timeout addresses are captured
// RULE13: swap field selects memory at segment 0, code 11 maps nothing
// RULE14: two 8-bit burst caps, zero means no splitting
// RULE15: sticky memory error flags, cleared by writing zero
// RULE16: init-done flags set once per memory and held
// RULE17: version tag carries the platform code in bits 20 to 19
// RULE18: undefined register bits read as zero
// RULE19: watchdog-to-network-core bit is reset only by the network core reset
// RULE20: fault capture holds the first fault until software reads it
package scrb_pkg;
  // register offsets
  localparam logic [7:0] OFS_ASYNC = 8'h0C;
  localparam logic [7:0] OFS_SYNC = 8'h10;
  localparam logic [7:0] OFS_CAUSE = 8'h14;
  localparam logic [7:0] OFS_PLL = 8'h18;
  localparam logic [7:0] OFS_SB_ADR = 8'h1C;
  localparam logic [7:0] OFS_SB_CTL = 8'h20;
  localparam logic [7:0] OFS_SB_MST = 8'h24;
  localparam logic [7:0] OFS_PB_ADR = 8'h28;
  localparam logic [7:0] OFS_EM_ADR = 8'h2C;
  localparam logic [7:0] OFS_SWAP = 8'h30;
  localparam logic [7:0] OFS_TAG = 8'h38;
  localparam logic [7:0] OFS_BURST = 8'h44;
  localparam logic [7:0] OFS_DIV = 8'h50;
  localparam logic [7:0] OFS_EDC = 8'h54;
  localparam logic [7:0] OFS_INIT = 8'h58;
  localparam logic [7:0] OFS_TCM = 8'h5C;
  localparam logic [7:0] OFS_POL = 8'h60;
  // async reset control fields
  localparam int ASR_WD_ALLOW = 0;
  localparam int ASR_SOFT_ALL = 1;
  localparam int ASR_SOFT_NC = 2;
  localparam int ASR_WD_NC = 3;
  localparam int ASR_ONE = 5;
  localparam int ASR_SOFT_CPU = 6;
  localparam int ASR_LEN_LSB = 16;
  localparam int PULSE_LEN_W = 16;
  localparam logic [15:0] PULSE_MIN_N = 16'h061A;
  // reset pulse channels
  localparam int CH_ALL = 0;
  localparam int CH_NC = 1;
  localparam int CH_CPU = 2;
  localparam int CH_WD = 3;
  localparam int CH_NUM = 4;
  // reset values and codes
  localparam logic WD_NC_RST = 1'b1;
  localparam logic [3:0] CAUSE_WDOG = 4'h1;
  localparam logic [3:0] CAUSE_SOFT = 4'h2;
  localparam logic [3:0] CAUSE_PWR = 4'h4;
  localparam logic [3:0] CAUSE_CPU = 4'h8;
  localparam logic [1:0] PLL_RST = 2'h1;
  localparam logic [7:0] DIV_RST = 8'h7C;
  localparam logic [1:0] SWAP_NONE = 2'h3;
  localparam logic [5:0] MST_VALID = 6'h3B;
  localparam int TAG_PLAT_LSB = 19;
  localparam int EDC_REG_W = 18;
  localparam int INIT_REG_W = 7;
endpackage

// ===== rtl/scrb_reset_pulse.sv
// reset pulse generator of programmable length
`timescale 1ns/1ns
module scrb_reset_pulse import scrb_pkg::*; #(
  parameter int LEN_W = PULSE_LEN_W,
  parameter int CNT_W = PULSE_LEN_W + 3
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // request
  input wire logic start,
  input wire logic [LEN_W-1:0] len,
  // pulse
  output logic pulse_out
);
  logic pulse_r;
  logic [CNT_W-1:0] cnt_r;

  if (CNT_W != LEN_W + 3) begin : g_chk
    $error("counter width must be length width plus three");
  end

  ////////////////////////////////////////////////////////////////////////////
  // RULE6: 8n+8 cycles
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      pulse_r <= 1'b0;
      cnt_r <= '0;
    end else if (start) begin
      pulse_r <= 1'b1;
      cnt_r <= {len, 3'h7};
    end else if (pulse_r) begin
      if (cnt_r == '0) begin
        pulse_r <= 1'b0;
      end else begin
        cnt_r <= cnt_r - 1'b1;
      end
    end
  end

  assign pulse_out = pulse_r;

  ////////////////////////////////////////////////////////////////////////////
  // length check helpers
  logic [CNT_W-1:0] hi_cnt;
  logic [CNT_W-1:0] exp_len;

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      hi_cnt <= '0;
      exp_len <= '0;
    end else if (start) begin
      hi_cnt <= '0;
      exp_len <= {len, 3'h0} + CNT_W'(8);
    end else if (pulse_r) begin
      hi_cnt <= hi_cnt + 1'b1;
    end
  end

  AST_PULSE_LEN: assert property (@(posedge clk_sys) disable iff (rst) // RULE6
    $fell(pulse_r) && !$past(rst) |-> hi_cnt == exp_len)
    else $error("reset pulse length wrong");

endmodule // scrb_reset_pulse

// ===== sim/scrb_apb_model.sv
// register bus master standing in for processor software
`timescale 1ns/1ns
module scrb_apb_model (
  // clock
  input wire logic clk_sys,
  // register bus
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [7:0] paddr,
  output logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h00000000;
  end
  ////////////////////////////////////////////////////////////////////////////////
  // one transfer, request held until pready is seen at an edge or 16 edges have passed
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic err);
    int n;
    @(posedge clk_sys);
    #1;
    psel = 1'b1;
    pwrite = wr;
    paddr = a;
    pwdata = d;
    @(posedge clk_sys);
    #1;
    penable = 1'b1;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (pready !== 1'b1 && n < 16);
    q = prdata;
    err = pslverr;
    #1;
    psel = 1'b0;
    penable = 1'b0;
    // released address and data lines no longer show the last value
    paddr = ~paddr;
    pwdata = ~pwdata;
  endtask
endmodule // scrb_apb_model

// ===== sim/test_system_control_reset_status_bank.sv
// self-checking bench of the system control register bank
`timescale 1ns/1ns
module test_system_control_reset_status_bank import scrb_pkg::*; ;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic nc_rst = 1'b1;
  logic wd_exp = 1'b0;
  logic lock_pin = 1'b1;
  logic lost_pin = 1'b0;
  logic sb_v = 1'b0;
  logic pb_v = 1'b0;
  logic em_v = 1'b0;
  logic [31:0] sb_a = 32'h00000000;
  logic [31:0] pb_a = 32'h00000000;
  logic [31:0] em_a = 32'h00000000;
  logic [5:0] sb_m = 6'h00;
  logic [13:0] edc_ev = 14'h0000;
  logic [4:0] init_in = 5'h00;
  logic psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr, dcap, icap;
  logic [31:0] pwdata, prdata;
  logic rs_all, rs_nc, rs_cpu, rs_wd, sr_per, sr_host, sr_nc, unmapped;
  logic [1:0] swap;
  int error_cnt = 0;
  int n_compared = 0;
  int cyc = 0;
  int cnt [4];
  logic [7:0] r_ofs [17] = '{OFS_ASYNC, OFS_SYNC, OFS_CAUSE, OFS_PLL, OFS_SB_ADR, OFS_SB_CTL,
    OFS_SB_MST, OFS_PB_ADR, OFS_EM_ADR, OFS_SWAP, OFS_TAG, OFS_BURST, OFS_DIV, OFS_EDC,
    OFS_INIT, OFS_TCM, OFS_POL};
  logic [31:0] r_rst [17] = '{32'h28, 32'h0, 32'h4, 32'h1, 32'h0, 32'h0, 32'h0, 32'h0,
    32'h0, 32'h0, 32'h000802A5, 32'h0, 32'h7C, 32'h0, 32'h0, 32'h0, 32'h0};
  initial begin
    forever #10 clk_sys = ~clk_sys;
  end
  ////////////////////////////////////////////////////////////////////////////////
  // label value is arbitrary
  scrb_bank #(.PLATFORM(2'h1), .VERSION_LABEL(11'h2A5)) u_scrb_bank (
    .clk_sys(clk_sys), .rst(rst), .netcore_rst_in(nc_rst),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .cpu_watchdog_expire(wd_exp),
    .soft_reset_all(rs_all), .soft_reset_netcore(rs_nc), .soft_reset_cpu(rs_cpu),
    .watchdog_reset(rs_wd), .periph_if_sync_reset(sr_per), .host_if_sync_reset(sr_host),
    .netcore_sync_reset(sr_nc), .pll_lock_pin(lock_pin), .pll_clk_lost_pin(lost_pin),
    .sb_fault_valid(sb_v), .sb_fault_addr(sb_a), .sb_fault_write(sb_a[0]),
    .sb_fault_size(sb_a[3:1]), .sb_fault_burst(sb_a[6:4]), .sb_fault_master(sb_m),
    .pb_fault_valid(pb_v), .pb_fault_addr(pb_a), .em_timeout_valid(em_v),
    .em_timeout_addr(em_a), .memory_error_events(edc_ev), .error_check_init_done(init_in),
    .seg0_swap_sel(swap), .seg0_unmapped(unmapped), .data_port_burst_cap(dcap),
    .instr_port_burst_cap(icap), .serial_clk_div(), .tcm_map(), .gpio_irq_pol());
  scrb_apb_model u_scrb_apb_model (
    .clk_sys(clk_sys), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error at %0t: value %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_cnt(input int got, input int exp);
    n_compared++;
    if (got != exp) begin
      error_cnt++;
      $display("Error at %0t: pulse cycles %0d expected %0d", $time, got, exp);
    end
  endtask
  task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d,
                     input logic ee);
    logic [31:0] q;
    logic err;
    u_scrb_apb_model.xfer(w, a, d, q, err);
    if (!w) chk_word(q, d);
    chk_word({31'h0, err}, {31'h0, ee});
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    acc(1'b1, a, d, 1'b0);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    acc(1'b0, a, e, 1'b0);
  endtask
  // count high cycles of the four pulse outputs
  task automatic watch(input int win);
    cnt = '{0, 0, 0, 0};
    repeat (win) begin
      @(negedge clk_sys);
      cnt[0] += int'(rs_all !== 1'b0);
      cnt[1] += int'(rs_nc !== 1'b0);
      cnt[2] += int'(rs_cpu !== 1'b0);
      cnt[3] += int'(rs_wd !== 1'b0);
    end
  endtask
  task automatic wdog();
    @(posedge clk_sys);
    #1;
    wd_exp = 1'b1;
    @(posedge clk_sys);
    #1;
    wd_exp = 1'b0;
  endtask
  task automatic fault(input logic [31:0] a, input logic [5:0] m);
    @(posedge clk_sys);
    #1;
    sb_v = 1'b1;
    pb_v = 1'b1;
    em_v = 1'b1;
    sb_a = a;
    pb_a = ~a;
    em_a = a + 32'h1;
    sb_m = m;
  endtask
  task automatic rst_pulse(input logic r, input logic n);
    @(posedge clk_sys);
    #1;
    rst = r;
    nc_rst = n;
    repeat (2) @(posedge clk_sys);
    #1;
    rst = 1'b0;
    nc_rst = 1'b0;
  endtask
  task automatic end_of_test();
    $display("errors %0d compared %0d", error_cnt, n_compared);
    if (error_cnt == 0 && n_compared > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      end_of_test();
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (2) @(posedge clk_sys);
    #1;
    rst = 1'b0;
    nc_rst = 1'b0;
    foreach (r_ofs[i]) rd(r_ofs[i], r_rst[i]);
    wr(OFS_CAUSE, 32'h0);
    rd(OFS_CAUSE, 32'h4);
    acc(1'b0, 8'h34, 32'h0, 1'b1);
    wr(OFS_SYNC, 32'hFFFFFFFF);
    rd(OFS_SYNC, 32'h7);
    wr(OFS_SYNC, 32'h5);
    chk_word({29'h0, sr_nc, sr_host, sr_per}, 32'h5);
    for (int c = 0; c < 4; c++) begin
      wr(OFS_SWAP, 32'(c));
      chk_word({29'h0, unmapped, swap}, {29'h0, c == 3, 2'(c)});
    end
    wr(OFS_BURST, 32'hFFFFA501);
    rd(OFS_BURST, 32'h0000A501);
    chk_word({16'h0, icap, dcap}, 32'h0000A501);
    wr(OFS_DIV, 32'hFFFFFFFF);
    rd(OFS_DIV, 32'hFF);
    wr(OFS_TCM, 32'hFFFFFFFF);
    rd(OFS_TCM, 32'hF);
    wr(OFS_POL, 32'hFFFFFFFF);
    rd(OFS_POL, 32'hFFFF);
    wr(OFS_ASYNC, 32'h00020002);
    watch(40);
    chk_cnt(cnt[0], 24);
    chk_cnt(cnt[1] + cnt[2], 0);
    rd(OFS_CAUSE, 32'h2);
    wr(OFS_ASYNC, 32'h00050004);
    watch(60);
    chk_cnt(cnt[1], 48);
    chk_cnt(cnt[0] + cnt[2], 0);
    rd(OFS_CAUSE, 32'h2);
    wr(OFS_ASYNC, 32'h00010040);
    watch(30);
    chk_cnt(cnt[2], 16);
    rd(OFS_CAUSE, 32'h8);
    // pulse length above the transceiver minimum
    wr(OFS_ASYNC, {PULSE_MIN_N + 16'h1, 16'h0002});
    watch(12530);
    chk_cnt(cnt[0], 8 * int'(PULSE_MIN_N) + 16);
    wr(OFS_ASYNC, 32'h0);
    wdog();
    watch(30);
    chk_cnt(cnt[3] + cnt[1], 0);
    rd(OFS_CAUSE, 32'h2);
    wr(OFS_ASYNC, 32'h00000009);
    wdog();
    watch(30);
    chk_cnt(cnt[3] + cnt[1], 16);
    rd(OFS_CAUSE, 32'h1);
    wr(OFS_ASYNC, 32'h00000001);
    wdog();
    watch(30);
    chk_cnt(cnt[3] * 100 + cnt[1], 800);
    rst_pulse(1'b1, 1'b0);
    rd(OFS_ASYNC, 32'h20);
    rd(OFS_CAUSE, 32'h4);
    rst_pulse(1'b0, 1'b1);
    rd(OFS_ASYNC, 32'h28);
    fault(32'h12345678, 6'h08);
    fault(32'h0BADF00D, 6'h01);
    @(posedge clk_sys);
    #1;
    sb_v = 1'b0;
    pb_v = 1'b0;
    em_v = 1'b0;
    rd(OFS_SB_ADR, 32'h12345678);
    rd(OFS_SB_CTL, 32'h78);
    rd(OFS_SB_MST, 32'h08);
    rd(OFS_PB_ADR, 32'hEDCBA987);
    rd(OFS_EM_ADR, 32'h12345679);
    fault(32'hCAFE0000, 6'h20);
    @(posedge clk_sys);
    #1;
    sb_v = 1'b0;
    pb_v = 1'b0;
    em_v = 1'b0;
    rd(OFS_SB_ADR, 32'hCAFE0000);
    rd(OFS_SB_MST, 32'h20);
    @(posedge clk_sys);
    #1;
    edc_ev = 14'h2009;
    init_in = 5'h15;
    lock_pin = 1'b0;
    lost_pin = 1'b1;
    @(posedge clk_sys);
    #1;
    edc_ev = 14'h0000;
    init_in = 5'h00;
    rd(OFS_EDC, 32'h2009);
    wr(OFS_EDC, 32'hFFFFE000);
    rd(OFS_EDC, 32'h2000);
    wr(OFS_EDC, 32'h0);
    rd(OFS_EDC, 32'h0);
    rd(OFS_INIT, 32'h15);
    rd(OFS_PLL, 32'h2);
    lock_pin = 1'b1;
    lost_pin = 1'b0;
    repeat (6) @(posedge clk_sys);
    rd(OFS_PLL, 32'h1);
    end_of_test();
  end
endmodule // test_system_control_reset_status_bank
